// ===== core/mie_core.sv
`timescale 1ns/1ps
// Summary of operation
// - one 14-bit word holds the opcode and all operands.
// - most instructions take one cycle; both subroutine jumps take two.
// - plain return, literal return and interrupt return take two cycles.
// - jumps, relative jumps and taken skips take two cycles.
// - indirect access through a pointer into program memory adds one cycle.
// - one instruction cycle is four clocks.
// - any file-register instruction reads the register before storing it.
// - the register-address field is a 7-bit file address 0x00 to 0x7f.
// - destination bit 0 writes the working register, 1 the file register.
// - the bit-position field picks one bit of an 8-bit register.
// - the pointer-number field picks one of two indirect pointers.
// - subroutine jump pushes next address, loads 11 bits and latch 6:3.
// - computed subroutine jump pushes, loads W low and latch 6:0 high.
// - watchdog clear pulses watchdog_clear for one clock and sets both flags.
// - complement inverts the register, routes by destination, updates Z.
module mie_core (
   clk,
   rst,
   pm_addr,
   pm_rdata,
   rf_addr,
   rf_rd,
   rf_rdata,
   rf_wr,
   rf_wdata,
   indirect_pointer0,
   indirect_pointer1,
   upper_counter_latch,
   working_reg,
   program_counter,
   zero_flag,
   watchdog_expiry_flag,
   power_down_flag,
   watchdog_clear,
   int_enable_set,
   instr_cycle_end
);
   import mie_pkg::*;

   input wire logic clk;
   input wire logic rst;
   output logic [mie_pkg::PC_W-1:0] pm_addr;
   input wire logic [mie_pkg::INSTR_W-1:0] pm_rdata;
   output logic [mie_pkg::PTR_W-1:0] rf_addr;
   output logic rf_rd;
   input wire logic [mie_pkg::DATA_W-1:0] rf_rdata;
   output logic rf_wr;
   output logic [mie_pkg::DATA_W-1:0] rf_wdata;
   input wire logic [mie_pkg::PTR_W-1:0] indirect_pointer0;
   input wire logic [mie_pkg::PTR_W-1:0] indirect_pointer1;
   input wire logic [mie_pkg::LATCH_W-1:0] upper_counter_latch;
   output logic [mie_pkg::DATA_W-1:0] working_reg;
   output logic [mie_pkg::PC_W-1:0] program_counter;
   output logic zero_flag;
   output logic watchdog_expiry_flag;
   output logic power_down_flag;
   output logic watchdog_clear;
   output logic int_enable_set;
   output logic instr_cycle_end;

   logic [1:0] q_reg;
   mie_state_e state_reg, state_next;
   logic [INSTR_W-1:0] ir_reg;
   logic [PC_W-1:0] pc_reg, pc_next;
   logic [DATA_W-1:0] w_reg, rd_reg, result;
   logic z_reg, expiry_reg, pdown_reg;
   logic [SP_W-1:0] sp_reg;
   logic [PC_W-1:0] stack_mem [STACK_DEPTH];

   mie_op_e op;
   logic [FADDR_W-1:0] file_addr;
   logic [2:0] bit_pos;
   logic dest_file, ptr_num, is_indirect, file_op;

   mie_decode u_decode (
      .instr(ir_reg),
      .op(op),
      .file_addr(file_addr),
      .bit_pos(bit_pos),
      .dest_file(dest_file),
      .ptr_num(ptr_num),
      .is_indirect(is_indirect),
      .file_op(file_op)
   );

   // quarter-rate sequencing: one phase per clock, four per cycle
   wire cyc_end = (q_reg == Q_LAST);
   wire [PTR_W-1:0] ptr_sel = ptr_num ? indirect_pointer1 :
      indirect_pointer0;
   wire ind_pm = is_indirect && ptr_sel[PTR_PM_BIT];
   wire in_exec = (state_reg == ST_EXEC);
   // pointer into program memory: spend a whole cycle fetching the operand
   wire extra_cyc = in_exec && ind_pm;
   wire run_op = (in_exec && !ind_pm) || (state_reg == ST_IND);
   wire exec_now = run_op && cyc_end;

   wire [DATA_W-1:0] bit_mask = 8'h01 << bit_pos;
   wire sel_bit = |(rd_reg & bit_mask);
   wire [DATA_W-1:0] lit8 = ir_reg[7:0];
   wire [LIT11_W-1:0] lit11 = ir_reg[10:0];
   wire [PC_W-1:0] br_off = {{(PC_W-BOFF_W){ir_reg[8]}}, ir_reg[8:0]};
   wire [PC_W-1:0] w_ext = {7'h00, w_reg};
   wire [SP_W-1:0] sp_dec = sp_reg - 4'h1;

   always_comb begin
      case (op)
         OP_MOVE_TO_F: result = w_reg;
         OP_IND_WR: result = w_reg;
         OP_CLEAR_F: result = 8'h00;
         OP_CLEAR_W: result = 8'h00;
         OP_COMP: result = ~rd_reg;
         OP_DEC: result = rd_reg - 8'h01;
         OP_DEC_SKIP: result = rd_reg - 8'h01;
         OP_INC: result = rd_reg + 8'h01;
         OP_INC_SKIP: result = rd_reg + 8'h01;
         OP_XOR_F: result = rd_reg ^ w_reg;
         OP_BIT_CLR: result = rd_reg & ~bit_mask;
         OP_BIT_SET: result = rd_reg | bit_mask;
         OP_LOAD_LIT: result = lit8;
         OP_RET_LIT: result = lit8;
         OP_XOR_LIT: result = lit8 ^ w_reg;
         default: result = rd_reg;
      endcase
   end

   wire res_zero = (result == 8'h00);
   wire routed = (op == OP_COMP) || (op == OP_DEC) || (op == OP_INC) ||
      (op == OP_MOVE_F) || (op == OP_XOR_F) || (op == OP_DEC_SKIP) ||
      (op == OP_INC_SKIP);
   // destination bit steers the routed operations
   wire to_file = (routed && dest_file) || (op == OP_MOVE_TO_F) ||
      (op == OP_CLEAR_F) || (op == OP_BIT_CLR) || (op == OP_BIT_SET) ||
      (op == OP_IND_WR);
   wire to_w = (routed && !dest_file) || (op == OP_CLEAR_W) ||
      (op == OP_LOAD_LIT) || (op == OP_RET_LIT) || (op == OP_XOR_LIT) ||
      (op == OP_IND_RD);
   // only these touch Z; the jumps leave every flag alone
   wire z_upd = (op == OP_CLEAR_F) || (op == OP_CLEAR_W) ||
      (op == OP_COMP) || (op == OP_DEC) || (op == OP_INC) ||
      (op == OP_MOVE_F) || (op == OP_XOR_F) || (op == OP_XOR_LIT) ||
      (op == OP_IND_RD);

   wire is_call = (op == OP_CALL) || (op == OP_WCALL);
   wire is_ret = (op == OP_RET) || (op == OP_RET_LIT) || (op == OP_IRET);
   wire skip_hit = ((op == OP_SKIP_CLR) && !sel_bit) ||
      ((op == OP_SKIP_SET) && sel_bit) ||
      (((op == OP_DEC_SKIP) || (op == OP_INC_SKIP)) && res_zero);
   // second cycle discards the word fetched behind a change of flow
   wire taken = is_call || is_ret || (op == OP_JUMP) ||
      (op == OP_RELJUMP) || (op == OP_WJUMP) ||
      skip_hit;

   always_comb begin
      case (op)
         OP_CALL: pc_next = {upper_counter_latch[6:3], lit11};
         OP_JUMP: pc_next = {upper_counter_latch[6:3], lit11};
         OP_WCALL: pc_next = {upper_counter_latch, w_reg};
         OP_RELJUMP: pc_next = pc_reg + br_off;
         OP_WJUMP: pc_next = pc_reg + w_ext;
         OP_RET: pc_next = stack_mem[sp_dec];
         OP_RET_LIT: pc_next = stack_mem[sp_dec];
         OP_IRET: pc_next = stack_mem[sp_dec];
         default: pc_next = pc_reg + 15'h0001;
      endcase
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_EXEC: begin
            if (ind_pm) state_next = ST_IND;
            else if (taken) state_next = ST_FLUSH;
            else state_next = ST_EXEC;
         end
         ST_IND: state_next = taken ? ST_FLUSH : ST_EXEC;
         ST_FLUSH: state_next = ST_EXEC;
         default: state_next = ST_FLUSH;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q_reg <= Q_READ;
      end else begin
         q_reg <= q_reg + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_FLUSH;
         ir_reg <= IR_RESET;
         pc_reg <= PC_RESET;
      end else if (cyc_end) begin
         state_reg <= state_next;
         if (!extra_cyc) begin
            ir_reg <= pm_rdata;
            pc_reg <= run_op ? pc_next : pc_reg + 15'h0001;
         end
      end
   end

   // operand read in phase one, from file or from program memory
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_reg <= W_RESET;
      end else if (q_reg == Q_CAPT && extra_cyc) begin
         rd_reg <= pm_rdata[7:0];
      end else if (q_reg == Q_CAPT && in_exec && file_op) begin
         rd_reg <= rf_rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         w_reg <= W_RESET;
         z_reg <= ZERO_RESET;
         expiry_reg <= EXPIRY_RESET;
         pdown_reg <= PDOWN_RESET;
      end else if (exec_now) begin
         if (to_w) w_reg <= result;
         if (z_upd) z_reg <= res_zero;
         if (op == OP_WDCLR) begin
            expiry_reg <= 1'b1;
            pdown_reg <= 1'b1;
         end
      end
   end

   // return stack; entries wrap like the pointer does
   always_ff @(posedge clk) begin
      if (rst) sp_reg <= 4'h0;
      else if (exec_now && is_call) sp_reg <= sp_reg + 4'h1;
      else if (exec_now && is_ret) sp_reg <= sp_dec;
   end

   genvar gi;
   generate
      for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_stack
         always_ff @(posedge clk) begin
            if (rst) begin
               stack_mem[gi] <= PC_RESET;
            end else if (exec_now && is_call && sp_reg == SP_W'(gi)) begin
               stack_mem[gi] <= pc_reg;
            end
         end
      end
   endgenerate

   // pc already points one past the executing word
   assign pm_addr = extra_cyc ? ptr_sel[PC_W-1:0] : pc_reg;
   assign rf_addr = is_indirect ? ptr_sel : {9'h000, file_addr};
   // the read happens even when the op only writes
   assign rf_rd = (q_reg == Q_READ) && in_exec && file_op && !ind_pm;
   // program memory is never written through a pointer
   assign rf_wr = exec_now && to_file && !ind_pm;
   assign rf_wdata = result;
   assign watchdog_clear = exec_now && (op == OP_WDCLR);
   assign int_enable_set = exec_now && (op == OP_IRET);
   assign instr_cycle_end = cyc_end;
   assign working_reg = w_reg;
   assign program_counter = pc_reg;
   assign zero_flag = z_reg;
   assign watchdog_expiry_flag = expiry_reg;
   assign power_down_flag = pdown_reg;
endmodule // mie_core

// ===== core/mie_decode.sv
`timescale 1ns/1ps
module mie_decode (
   input wire logic [mie_pkg::INSTR_W-1:0] instr,
   output mie_pkg::mie_op_e op,
   output logic [mie_pkg::FADDR_W-1:0] file_addr,
   output logic [2:0] bit_pos,
   output logic dest_file,
   output logic ptr_num,
   output logic is_indirect,
   output logic file_op
);
   import mie_pkg::*;

   wire [1:0] cls = instr[13:12];
   wire [3:0] sub = instr[11:8];
   wire misc = (cls == CLS_BYTE) && (instr[11:7] == 5'h00);

   always_comb begin
      op = OP_NONE;
      case (cls)
         CLS_BYTE: begin
            case (sub)
               SUB_MISC: begin
                  if (instr[7]) op = OP_MOVE_TO_F;
                  else if (instr[6:3] == MISC_IND_RD) op = OP_IND_RD;
                  else if (instr[6:3] == MISC_IND_WR) op = OP_IND_WR;
                  else if (instr[6:0] == MISC_RET) op = OP_RET;
                  else if (instr[6:0] == MISC_IRET) op = OP_IRET;
                  else if (instr[6:0] == MISC_WCALL) op = OP_WCALL;
                  else if (instr[6:0] == MISC_WJUMP) op = OP_WJUMP;
                  else if (instr[6:0] == MISC_WDCLR) op = OP_WDCLR;
                  else op = OP_NONE;
               end
               SUB_CLEAR: op = instr[7] ? OP_CLEAR_F : OP_CLEAR_W;
               SUB_DEC: op = OP_DEC;
               SUB_XOR: op = OP_XOR_F;
               SUB_MOVE: op = OP_MOVE_F;
               SUB_COMP: op = OP_COMP;
               SUB_INC: op = OP_INC;
               SUB_DECSKIP: op = OP_DEC_SKIP;
               SUB_INCSKIP: op = OP_INC_SKIP;
               default: op = OP_NONE;
            endcase
         end
         CLS_BIT: begin
            case (instr[11:10])
               2'h0: op = OP_BIT_CLR;
               2'h1: op = OP_BIT_SET;
               2'h2: op = OP_SKIP_CLR;
               default: op = OP_SKIP_SET;
            endcase
         end
         CLS_JUMP: op = instr[11] ? OP_JUMP : OP_CALL;
         default: begin
            if (instr[11:9] == LIT_RELJUMP) op = OP_RELJUMP;
            else if (sub == LIT_LOAD) op = OP_LOAD_LIT;
            else if (sub == LIT_RETURN) op = OP_RET_LIT;
            else if (sub == LIT_XOR) op = OP_XOR_LIT;
            else op = OP_NONE;
         end
      endcase
   end

   // operand fields sit at fixed places in every word
   assign file_addr = instr[6:0];
   assign bit_pos = instr[9:7];
   assign dest_file = instr[7];
   assign file_op = (cls == CLS_BIT) ||
      ((cls == CLS_BYTE) && !(misc && op != OP_IND_RD && op != OP_IND_WR)
       && op != OP_CLEAR_W);
   wire ind_move = (op == OP_IND_RD) || (op == OP_IND_WR);
   // pointer number from the move-indirect word or the access location
   assign ptr_num = ind_move ? instr[2] : file_addr[0];
   assign is_indirect = file_op && (ind_move ||
      file_addr == INDIRECT0_ADDR || file_addr == INDIRECT1_ADDR);
endmodule // mie_decode

// ===== core/mie_pkg.sv
package mie_pkg;

   localparam int INSTR_W = 14;
   localparam int PC_W = 15;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PTR_W = 16;
   localparam int LATCH_W = 7;
   localparam int LIT11_W = 11;
   localparam int BOFF_W = 9;
   localparam int STACK_DEPTH = 16;
   localparam int SP_W = 4;

   // four oscillator clocks per instruction cycle
   localparam int OSC_PER_CYCLE = 4;
   localparam logic [1:0] Q_READ = 2'h0;
   localparam logic [1:0] Q_CAPT = 2'h1;
   localparam logic [1:0] Q_LAST = 2'h3;

   localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
   localparam logic [INSTR_W-1:0] IR_RESET = 14'h0000;
   localparam logic [DATA_W-1:0] W_RESET = 8'h00;
   localparam logic ZERO_RESET = 1'b0;
   localparam logic EXPIRY_RESET = 1'b1;
   localparam logic PDOWN_RESET = 1'b1;

   // indirect access locations and program-memory flag of a pointer
   localparam logic [FADDR_W-1:0] INDIRECT0_ADDR = 7'h00;
   localparam logic [FADDR_W-1:0] INDIRECT1_ADDR = 7'h01;
   localparam int PTR_PM_BIT = 15;

   // instruction classes, bits 13:12
   localparam logic [1:0] CLS_BYTE = 2'h0;
   localparam logic [1:0] CLS_BIT = 2'h1;
   localparam logic [1:0] CLS_JUMP = 2'h2;
   localparam logic [1:0] CLS_LIT = 2'h3;

   // byte class sub-codes, bits 11:8
   localparam logic [3:0] SUB_MISC = 4'h0;
   localparam logic [3:0] SUB_CLEAR = 4'h1;
   localparam logic [3:0] SUB_DEC = 4'h3;
   localparam logic [3:0] SUB_XOR = 4'h6;
   localparam logic [3:0] SUB_MOVE = 4'h8;
   localparam logic [3:0] SUB_COMP = 4'h9;
   localparam logic [3:0] SUB_INC = 4'ha;
   localparam logic [3:0] SUB_DECSKIP = 4'hb;
   localparam logic [3:0] SUB_INCSKIP = 4'hf;

   // misc codes, bits 6:0 with bits 11:7 zero; move-indirect codes in bits 6:3
   localparam logic [6:0] MISC_NONE = 7'h00;
   localparam logic [6:0] MISC_RET = 7'h08;
   localparam logic [6:0] MISC_IRET = 7'h09;
   localparam logic [6:0] MISC_WCALL = 7'h0a;
   localparam logic [6:0] MISC_WJUMP = 7'h0b;
   localparam logic [6:0] MISC_WDCLR = 7'h64;
   localparam logic [3:0] MISC_IND_RD = 4'h2;
   localparam logic [3:0] MISC_IND_WR = 4'h3;

   // literal class sub-codes, bits 11:8 and 11:9
   localparam logic [3:0] LIT_LOAD = 4'h0;
   localparam logic [3:0] LIT_RETURN = 4'h4;
   localparam logic [3:0] LIT_XOR = 4'ha;
   localparam logic [2:0] LIT_RELJUMP = 3'h1;

   typedef enum logic [4:0] {
      OP_NONE, OP_MOVE_TO_F, OP_CLEAR_F, OP_CLEAR_W, OP_COMP, OP_DEC,
      OP_INC, OP_MOVE_F, OP_XOR_F, OP_DEC_SKIP, OP_INC_SKIP, OP_BIT_CLR,
      OP_BIT_SET, OP_SKIP_CLR, OP_SKIP_SET, OP_LOAD_LIT, OP_RET_LIT,
      OP_XOR_LIT, OP_CALL, OP_JUMP, OP_WCALL, OP_WJUMP, OP_RELJUMP,
      OP_RET, OP_IRET, OP_WDCLR, OP_IND_RD, OP_IND_WR
   } mie_op_e;

   typedef enum logic [2:0] {
      ST_EXEC = 3'b001,
      ST_IND = 3'b010,
      ST_FLUSH = 3'b100
   } mie_state_e;

endpackage

// ===== tb/mie_core_properties.sv
`timescale 1ns/1ps
module mie_core_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic [mie_pkg::PTR_W-1:0] rf_addr,
   input wire logic rf_rd,
   input wire logic rf_wr,
   input wire logic [mie_pkg::PTR_W-1:0] indirect_pointer0,
   input wire logic [mie_pkg::PTR_W-1:0] indirect_pointer1,
   input wire logic [mie_pkg::PC_W-1:0] program_counter,
   input wire logic zero_flag,
   input wire logic watchdog_expiry_flag,
   input wire logic power_down_flag,
   input wire logic watchdog_clear,
   input wire logic instr_cycle_end
);
   import mie_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   cycle_end_period_a: assert property (
      instr_cycle_end |=> !instr_cycle_end [*3] ##1 instr_cycle_end)
      else $error("cycle end pulse not every fourth clock");
   read_before_write_a: assert property (
      rf_wr |-> $past(rf_rd, 3))
      else $error("file write without read three clocks earlier");
   write_at_end_a: assert property (
      rf_wr |-> instr_cycle_end)
      else $error("file write outside last phase");
   read_phase_a: assert property (
      rf_rd |-> ##3 instr_cycle_end)
      else $error("file read not in first phase");
   wd_flags_set_a: assert property (
      watchdog_clear |=> watchdog_expiry_flag && power_down_flag)
      else $error("flags not set after watchdog clear");
   wd_pulse_a: assert property (
      watchdog_clear |-> instr_cycle_end ##1 !watchdog_clear)
      else $error("watchdog clear pulse malformed");
   direct_range_a: assert property (
      rf_rd && rf_addr != indirect_pointer0 && rf_addr != indirect_pointer1
      |-> rf_addr[15:7] == 9'h000)
      else $error("direct file address beyond seven bits");
   zero_at_end_a: assert property (
      $changed(zero_flag) |-> $past(instr_cycle_end))
      else $error("zero flag moved inside an instruction cycle");
   pc_at_end_a: assert property (
      $changed(program_counter) |-> $past(instr_cycle_end))
      else $error("program counter moved inside an instruction cycle");
   cover property (rf_wr);
   cover property (watchdog_clear);
   cover property (rf_rd ##3 !rf_wr);
endmodule // mie_core_properties
bind mie_core mie_core_properties u_props (.clk(clk), .rst(rst),
   .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_wr(rf_wr),
   .indirect_pointer0(indirect_pointer0),
   .indirect_pointer1(indirect_pointer1),
   .program_counter(program_counter), .zero_flag(zero_flag),
   .watchdog_expiry_flag(watchdog_expiry_flag),
   .power_down_flag(power_down_flag), .watchdog_clear(watchdog_clear),
   .instr_cycle_end(instr_cycle_end));

// ===== tb/mie_mem_model.sv
`timescale 1ns/1ps
module mie_mem_model (
   input wire logic clk,
   input wire logic [mie_pkg::PC_W-1:0] pm_addr,
   output logic [mie_pkg::INSTR_W-1:0] pm_rdata,
   input wire logic [mie_pkg::PTR_W-1:0] rf_addr,
   input wire logic rf_rd,
   output logic [mie_pkg::DATA_W-1:0] rf_rdata,
   input wire logic rf_wr,
   input wire logic [mie_pkg::DATA_W-1:0] rf_wdata
);
   import mie_pkg::*;
   logic [INSTR_W-1:0] prog [0:32767];
   logic [DATA_W-1:0] regs [0:127];
   logic rd_q = 1'b0;
   wire logic rd_win;
   assign pm_rdata = prog[pm_addr];
   // data only held in the read window, inverted otherwise
   assign rd_win = rf_rd | rd_q;
   assign rf_rdata = rd_win ? regs[rf_addr[6:0]] : ~regs[rf_addr[6:0]];
   always @(posedge clk) begin
      rd_q <= rf_rd;
      if (rf_wr === 1'b1) begin
         regs[rf_addr[6:0]] <= rf_wdata;
      end
   end
endmodule // mie_mem_model

// ===== tb/tb_mie_core.sv
`timescale 1ns/1ps
module tb_mie_core;
   import mie_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [PC_W-1:0] pm_addr;
   logic [INSTR_W-1:0] pm_rdata;
   logic [PTR_W-1:0] rf_addr;
   logic rf_rd, rf_wr, zero_flag, wd_exp, pdown, wd_clr, ie_set, cyc_end;
   logic [DATA_W-1:0] rf_rdata, rf_wdata, w;
   logic [PC_W-1:0] pc;
   logic [PTR_W-1:0] ptr0 = 16'h0030;
   logic [PTR_W-1:0] ptr1 = 16'h8100;
   logic [LATCH_W-1:0] latch = 7'h09;
   int n_errors = 0;
   int tests_run = 0;
   int n_ends = 0;
   int n_wdc = 0;
   int n_ie = 0;
   always #10 clk = ~clk;
   mie_core u_dut (.clk(clk), .rst(rst), .pm_addr(pm_addr),
      .pm_rdata(pm_rdata), .rf_addr(rf_addr), .rf_rd(rf_rd),
      .rf_rdata(rf_rdata), .rf_wr(rf_wr), .rf_wdata(rf_wdata),
      .indirect_pointer0(ptr0), .indirect_pointer1(ptr1),
      .upper_counter_latch(latch), .working_reg(w),
      .program_counter(pc), .zero_flag(zero_flag),
      .watchdog_expiry_flag(wd_exp), .power_down_flag(pdown),
      .watchdog_clear(wd_clr), .int_enable_set(ie_set),
      .instr_cycle_end(cyc_end));
   mie_mem_model u_mem (.clk(clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
      .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_rdata(rf_rdata),
      .rf_wr(rf_wr), .rf_wdata(rf_wdata));
   always @(posedge clk) begin
      if (rst) begin
         n_ends <= 0;
      end else if (cyc_end === 1'b1) begin
         n_ends <= n_ends + 1;
      end
      if (!rst && wd_clr === 1'b1) begin
         n_wdc <= n_wdc + 1;
      end
      if (!rst && ie_set === 1'b1) begin
         n_ie <= n_ie + 1;
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // waits until the given number of instruction cycles has ended
   task automatic wait_to(input int k);
      while (n_ends < k) @(negedge clk);
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #10000;
      n_errors++;
      report_and_stop;
   end
   initial begin
      for (int i = 0; i < 32768; i++) u_mem.prog[i] = 14'h0000;
      for (int i = 0; i < 128; i++) u_mem.regs[i] = 8'h00;
      u_mem.regs[7'h20] = 8'h0f;
      u_mem.regs[7'h21] = 8'hff;
      u_mem.regs[7'h22] = 8'h01;
      u_mem.regs[7'h30] = 8'h3c;
      u_mem.prog[15'h000] = 14'h305a;
      u_mem.prog[15'h001] = 14'h0920;
      u_mem.prog[15'h002] = 14'h09a1;
      u_mem.prog[15'h003] = 14'h0064;
      u_mem.prog[15'h004] = 14'h2040;
      u_mem.prog[15'h005] = 14'h0014;
      u_mem.prog[15'h006] = 14'h0ba2;
      u_mem.prog[15'h007] = 14'h3077;
      u_mem.prog[15'h008] = 14'h0010;
      u_mem.prog[15'h009] = 14'h17a3;
      u_mem.prog[15'h00a] = 14'h1fa3;
      u_mem.prog[15'h00b] = 14'h30ee;
      u_mem.prog[15'h00c] = 14'h2850;
      u_mem.prog[15'h850] = 14'h320f;
      u_mem.prog[15'h860] = 14'h3002;
      u_mem.prog[15'h861] = 14'h000b;
      u_mem.prog[15'h862] = 14'h30ee;
      u_mem.prog[15'h864] = 14'h2070;
      u_mem.prog[15'h870] = 14'h0009;
      u_mem.prog[15'h100] = 14'h00a5;
      u_mem.prog[15'h840] = 14'h3033;
      u_mem.prog[15'h841] = 14'h000a;
      u_mem.prog[15'h843] = 14'h0008;
      u_mem.prog[15'h933] = 14'h3a33;
      u_mem.prog[15'h934] = 14'h0008;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      check({8'h00, w}, 16'h0000);
      check({14'h0, wd_exp, pdown}, 16'h0003);
      $display("test reset done");
      wait_to(2);
      check({8'h00, w}, 16'h005a);
      wait_to(3);
      check({8'h00, w}, 16'h00f0);
      check({15'h0, zero_flag}, 16'h0000);
      check({8'h00, u_mem.regs[7'h20]}, 16'h000f);
      wait_to(4);
      check({8'h00, u_mem.regs[7'h21]}, 16'h0000);
      check({15'h0, zero_flag}, 16'h0001);
      check({8'h00, w}, 16'h00f0);
      wait_to(5);
      check(16'(n_wdc), 16'h0001);
      check({14'h0, wd_exp, pdown}, 16'h0003);
      $display("test register ops done");
      wait_to(6);
      check({1'b0, pc}, 16'h0840);
      wait_to(7);
      check({1'b0, pc}, 16'h0841);
      wait_to(9);
      check({1'b0, pc}, 16'h0933);
      check({15'h0, zero_flag}, 16'h0001);
      wait_to(11);
      check({8'h00, w}, 16'h0000);
      wait_to(12);
      check({1'b0, pc}, 16'h0842);
      wait_to(13);
      check({1'b0, pc}, 16'h0843);
      wait_to(15);
      check({1'b0, pc}, 16'h0005);
      $display("test calls done");
      wait_to(18);
      check({8'h00, w}, 16'h00a5);
      check({1'b0, pc}, 16'h0007);
      wait_to(20);
      check({8'h00, u_mem.regs[7'h22]}, 16'h0000);
      check({8'h00, w}, 16'h00a5);
      check({1'b0, pc}, 16'h0009);
      $display("test indirect and skip done");
      wait_to(21);
      check({8'h00, w}, 16'h003c);
      wait_to(22);
      check({8'h00, u_mem.regs[7'h23]}, 16'h0080);
      wait_to(24);
      check({8'h00, w}, 16'h003c);
      check({1'b0, pc}, 16'h000d);
      wait_to(25);
      check({1'b0, pc}, 16'h0850);
      wait_to(27);
      check({1'b0, pc}, 16'h0860);
      wait_to(30);
      check({1'b0, pc}, 16'h0864);
      wait_to(31);
      check({8'h00, w}, 16'h0002);
      wait_to(34);
      check({1'b0, pc}, 16'h0865);
      check(16'(n_ie), 16'h0001);
      $display("test branches done");
      report_and_stop;
   end
endmodule // tb_mie_core
